// ==== logic/vic_consts.svh ====
/*
 * Register offsets, field positions and reset values of the vectored interrupt controller register block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// Byte offsets on the register bus
`define VIC_OFF_FAST_VECT    12'h104
`define VIC_OFF_NORM_VECT    12'h100
`define VIC_OFF_PENDING      12'h10C
`define VIC_OFF_ENABLE       12'h110
`define VIC_OFF_CORE_STAT    12'h114
`define VIC_OFF_ENABLE_CMD   12'h120
`define VIC_OFF_DISABLE_CMD  12'h124
`define VIC_OFF_CLEAR_CMD    12'h128
`define VIC_OFF_SET_CMD      12'h12C
`define VIC_OFF_EOS_CMD      12'h130
`define VIC_OFF_STRAY        12'h134
`define VIC_OFF_DEBUG        12'h138
`define VIC_OFF_FF_ON        12'h140
`define VIC_OFF_FF_OFF       12'h144
`define VIC_OFF_FF_STATE     12'h148
`define VIC_OFF_FAST_HANDLER 12'h150
`define VIC_OFF_NORM_HANDLER 12'h154

// Field positions
`define VIC_BIT_FAST_SRC     0
`define VIC_BIT_FAST_LINE    0
`define VIC_BIT_NORM_LINE    1
`define VIC_BIT_PROTECTION_ENABLE         0
`define VIC_BIT_GMASK        1

// Reset values and the writable bits of fast forcing
`define VIC_RST_WORD         32'h0000_0000
`define VIC_RST_DEBUG        2'h0
`define VIC_FF_WRITABLE      32'hFFFF_FFFE

// Bus answers
`define VIC_RESP_OKAY        2'h0
`define VIC_RESP_SLVERR      2'h2

`endif

// ==== logic/vic_pkg.sv ====
/*
 * Types of the vectored interrupt controller register block.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none

package vic_pkg;
   typedef logic [31:0] vic_word_t;
   typedef enum logic [1:0] {
      VIC_IDLE,
      VIC_IN_SERVICE
   } vic_svc_t;
endpackage

`default_nettype wire

// ==== logic/vic_regs.sv ====
/*
 * Vectored interrupt controller register block: pending, enable, fast forcing,
 * command registers, vector reads and the two processor request lines.
 * Assumes sources are synchronous high levels and an AXI4-Lite master on one clock.
 */
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "vic_consts.svh"

module vic_regs (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Interrupt sources, active high levels
   input  wire logic [31:0] irq_src,
   // Processor request lines, active low
   output logic             fast_request_line_n,
   output logic             normal_request_line_n,
   // Current source number, status only
   output logic [4:0]       cur_source,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   vic_pkg::vic_word_t pending_r;
   vic_pkg::vic_word_t enable_r;
   vic_pkg::vic_word_t ff_r;
   vic_pkg::vic_word_t stray_r;
   vic_pkg::vic_word_t fast_handler_r;
   vic_pkg::vic_word_t norm_handler_r;
   vic_pkg::vic_word_t src_d_r;
   logic [1:0]         debug_r;
   vic_pkg::vic_svc_t  svc_r;
   logic [4:0]         cur_id_r;
   logic [11:0]        aw_addr_r;
   logic [31:0]        w_data_r;
   logic [3:0]         w_strb_r;
   logic               aw_held_r;
   logic               w_held_r;
   logic               wr_go;
   logic [11:0]        wa;
   logic [31:0]        wd;
   vic_pkg::vic_word_t active;
   logic               fast_want;
   logic               norm_want;
   logic               norm_found;
   logic [4:0]         norm_id;
   vic_pkg::vic_word_t rd_word;
   logic [1:0]         rd_resp;
   logic               wr_hit;

   // Write channel capture: address and data taken in either order
   assign wa    = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wd    = w_held_r ? w_data_r : s_axi_wdata;
   assign wr_go = (aw_held_r | (s_axi_awvalid & s_axi_awready))
                & (w_held_r | (s_axi_wvalid & s_axi_wready));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
      end
   end

   // Write readies from flops: next value of "channel not held and no response waiting"
   // A waiting response refuses both channels until bready is seen
   // Registered so no output depends combinationally on a valid
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else if (wr_go) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~(s_axi_bvalid & ~s_axi_bready);
         s_axi_wready  <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~(s_axi_bvalid & ~s_axi_bready);
      end
   end

   // Write decode: writable word addresses answer OKAY, others SLVERR
   always_comb begin
      case ({wa[11:2], 2'b00})
         `VIC_OFF_ENABLE_CMD, `VIC_OFF_DISABLE_CMD, `VIC_OFF_CLEAR_CMD,
         `VIC_OFF_SET_CMD, `VIC_OFF_EOS_CMD, `VIC_OFF_STRAY, `VIC_OFF_DEBUG,
         `VIC_OFF_FF_ON, `VIC_OFF_FF_OFF, `VIC_OFF_FAST_HANDLER,
         `VIC_OFF_NORM_HANDLER: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `VIC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Command hits per register
   logic cmd_en;
   logic cmd_dis;
   logic cmd_clr;
   logic cmd_set;
   logic cmd_eos;
   logic cmd_ffon;
   logic cmd_ffoff;
   assign cmd_en    = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_ENABLE_CMD;
   assign cmd_dis   = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_DISABLE_CMD;
   assign cmd_clr   = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_CLEAR_CMD;
   assign cmd_set   = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_SET_CMD;
   assign cmd_eos   = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_EOS_CMD;
   assign cmd_ffon  = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_FF_ON;
   assign cmd_ffoff = wr_go && {wa[11:2], 2'b00} == `VIC_OFF_FF_OFF;

   // Rising-edge history of the sources
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_d_r <= `VIC_RST_WORD;
      end else begin
         src_d_r <= irq_src;
      end
   end

   // Per-source pending and enable; source rise and set win over clear
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_src
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               pending_r[gi] <= 1'b0;
            end else if ((irq_src[gi] & ~src_d_r[gi]) | (cmd_set & wd[gi])) begin
               pending_r[gi] <= 1'b1;
            end else if (cmd_clr & wd[gi]) begin
               pending_r[gi] <= 1'b0;
            end else if (svc_r == vic_pkg::VIC_IDLE && norm_found && norm_id == gi && cmd_eos) begin
               pending_r[gi] <= pending_r[gi];
            end
         end
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               enable_r[gi] <= 1'b0;
            end else if (cmd_en & wd[gi]) begin
               enable_r[gi] <= 1'b1;
            end else if (cmd_dis & wd[gi]) begin
               enable_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Fast forcing state, bit 0 never set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ff_r <= `VIC_RST_WORD;
      end else if (cmd_ffon) begin
         ff_r <= (ff_r | (wd & `VIC_FF_WRITABLE)) & ~(cmd_ffoff ? wd : 32'h0000_0000);
      end else if (cmd_ffoff) begin
         ff_r <= ff_r & ~wd;
      end
   end

   // Software-held words: stray address, handlers, debug control
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stray_r        <= `VIC_RST_WORD;
         fast_handler_r <= `VIC_RST_WORD;
         norm_handler_r <= `VIC_RST_WORD;
         debug_r        <= `VIC_RST_DEBUG;
      end else if (wr_go) begin
         case ({wa[11:2], 2'b00})
            `VIC_OFF_STRAY:        stray_r <= wd;
            `VIC_OFF_FAST_HANDLER: fast_handler_r <= wd;
            `VIC_OFF_NORM_HANDLER: norm_handler_r <= wd;
            `VIC_OFF_DEBUG:        debug_r <= wd[1:0];
            default:               debug_r <= debug_r;
         endcase
      end
   end

   // Request decisions: forced sources go to the fast line
   assign active    = pending_r & enable_r;
   assign fast_want = active[`VIC_BIT_FAST_SRC] | (|(active & ff_r));
   always_comb begin
      norm_found = 1'b0;
      norm_id    = 5'h00;
      for (int i = 31; i >= 1; i--) begin
         if (active[i] && !ff_r[i]) begin
            norm_found = 1'b1;
            norm_id    = 5'(i);
         end
      end
   end
   assign norm_want = norm_found | (svc_r == vic_pkg::VIC_IN_SERVICE);

   // Service state: a normal read makes the lowest source current, end-of-service releases it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         svc_r    <= vic_pkg::VIC_IDLE;
         cur_id_r <= 5'h00;
      end else begin
         case (svc_r)
            vic_pkg::VIC_IDLE: begin
               if (s_axi_arvalid && s_axi_arready && norm_found &&
                   {s_axi_araddr[11:2], 2'b00} == `VIC_OFF_NORM_VECT) begin
                  svc_r    <= vic_pkg::VIC_IN_SERVICE;
                  cur_id_r <= norm_id;
               end
            end
            vic_pkg::VIC_IN_SERVICE: begin
               if (cmd_eos) begin
                  svc_r <= vic_pkg::VIC_IDLE;
               end
            end
            default: svc_r <= vic_pkg::VIC_IDLE;
         endcase
      end
   end

   // Request lines, held inactive under the general mask
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fast_request_line_n   <= 1'b1;
         normal_request_line_n <= 1'b1;
         cur_source            <= 5'h00;
      end else begin
         fast_request_line_n   <= ~(fast_want & ~debug_r[`VIC_BIT_GMASK]);
         normal_request_line_n <= ~(norm_found & (svc_r == vic_pkg::VIC_IDLE) & ~debug_r[`VIC_BIT_GMASK]);
         cur_source            <= cur_id_r;
      end
   end

   // Read decode
   always_comb begin
      rd_resp = `VIC_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
         `VIC_OFF_PENDING:      rd_word = pending_r;
         `VIC_OFF_ENABLE:       rd_word = enable_r;
         `VIC_OFF_CORE_STAT:    rd_word = {30'h0, ~normal_request_line_n, ~fast_request_line_n};
         `VIC_OFF_STRAY:        rd_word = stray_r;
         `VIC_OFF_DEBUG:        rd_word = {30'h0, debug_r};
         `VIC_OFF_FF_STATE:     rd_word = ff_r;
         `VIC_OFF_FAST_HANDLER: rd_word = fast_handler_r;
         `VIC_OFF_NORM_HANDLER: rd_word = norm_handler_r;
         `VIC_OFF_NORM_VECT:    rd_word = norm_found ? norm_handler_r : stray_r;
         `VIC_OFF_FAST_VECT:    rd_word = fast_want ? fast_handler_r : stray_r;
         `VIC_OFF_ENABLE_CMD, `VIC_OFF_DISABLE_CMD, `VIC_OFF_CLEAR_CMD, `VIC_OFF_SET_CMD,
         `VIC_OFF_EOS_CMD, `VIC_OFF_FF_ON, `VIC_OFF_FF_OFF: rd_word = 32'h0000_0000;
         default: begin
            rd_word = 32'h0000_0000;
            rd_resp = `VIC_RESP_SLVERR;
         end
      endcase
   end

   // Read ready from a flop: next value of "no read data waiting"
   // A second address is refused until rready takes the data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= ~(s_axi_arvalid & s_axi_arready) & ~(s_axi_rvalid & ~s_axi_rready);
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `VIC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== tb/vic_regs_chk.sv ====
/* Checker of the interrupt controller register block: request lines and bus handshakes.
   Assumes one clock, synchronous active-high reset, bound to vic_regs. */
`timescale 1ns/10ps
`default_nettype none
module vic_regs_chk (
   // Clock, reset, sources and lines
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [31:0] irq_src,
   input wire logic        fast_request_line_n,
   input wire logic        normal_request_line_n,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Reset leaves both lines inactive
   a_reset_idle: assert property (disable iff (1'b0) rst |=> fast_request_line_n && normal_request_line_n)
      else $error("line active after reset");
   // Fast line moves only after a write or a source change
   a_fast_cause: assert property ($changed(fast_request_line_n) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(irq_src, 2) != $past(irq_src, 4))
      else $error("fast line moved without cause");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
      else $error("bad write response code");
   a_resp_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("response not withdrawn");
endmodule
bind vic_regs vic_regs_chk u_chk (.sys_clk(sys_clk), .rst(rst), .irq_src(irq_src),
   .fast_request_line_n(fast_request_line_n), .normal_request_line_n(normal_request_line_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ==== tb/vic_src_model.sv ====
/* Peripheral source model: each requested source gives a level pulse of three cycles.
   Assumes requests from the bench on sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module vic_src_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Bench request, one bit per source
   input  wire logic [31:0] fire,
   // Source levels
   output var logic [31:0]  irq_src
);
   logic [1:0] hold_r [32];
   // Count down the high time of each source
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 32; i++) begin
         if (rst) hold_r[i] <= 2'h0;
         else if (fire[i]) hold_r[i] <= 2'h3;
         else if (hold_r[i] != 2'h0) hold_r[i] <= hold_r[i] - 2'h1;
      end
   end
   // Level is high while the count runs
   always_comb for (int i = 0; i < 32; i++) irq_src[i] = (hold_r[i] != 2'h0);
endmodule
`default_nettype wire

// ==== tb/vic_regs_tb.sv ====
/* Self-checking bench of the interrupt controller register block.
   Assumes header, design, checker and source model compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`include "vic_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %h %h", $time, g, e); end end
module vic_regs_tb;
   localparam logic [1:0]  rs_ok = 2'h0;
   localparam logic [1:0]  rs_er = 2'h2;
   localparam logic [31:0] zero  = 32'h0;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] fire = 32'h0;
   logic [31:0] irq_src, w_d = 32'h0, r_d, v, en, pend, h;
   logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
   logic [1:0]  b_rs, r_rs;
   logic [3:0]  w_s = 4'hF;
   logic        aw_v = 1'b0, w_v = 1'b0, b_k = 1'b0, ar_v = 1'b0, r_k = 1'b0;
   logic        aw_k, w_k, b_v, ar_k, r_v, fl_n, nl_n;
   logic [4:0]  cur;
   logic [33:0] note [$];
   logic [33:0] e;
   int          n_fail = 0, checks_done = 0, seed = 56567;
   vic_regs u_dut (.sys_clk(sys_clk), .rst(rst), .irq_src(irq_src), .fast_request_line_n(fl_n),
      .normal_request_line_n(nl_n), .cur_source(cur), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_k), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_k),
      .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_k), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_k), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_k));
   vic_src_model u_src (.sys_clk(sys_clk), .rst(rst), .fire(fire), .irq_src(irq_src));
   // Clock
   always #2 sys_clk = ~sys_clk;
   task automatic final_report;
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One bus transfer; the expected answer goes on the queue first
   task automatic bus(input int rd, input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
      int k;
      @(posedge sys_clk);
      note.push_back({rs, rd ? d : zero});
      if (rd) begin
         ar_a <= a;
         ar_v <= 1'b1;
         r_k <= 1'b1;
      end else begin
         aw_a <= a;
         w_d <= d;
         aw_v <= 1'b1;
         w_v <= 1'b1;
         b_k <= 1'b1;
      end
      k = 0;
      do begin
         @(posedge sys_clk);
         if (ar_k) ar_v <= 1'b0;
         if (aw_k) aw_v <= 1'b0;
         if (w_k) w_v <= 1'b0;
         k++;
      end while (!(r_v && r_k) && !(b_v && b_k) && k < 40);
      r_k <= 1'b0;
      b_k <= 1'b0;
      if (k == 40) begin
         n_fail++;
         final_report();
      end
   endtask
   // Line levels once the last change has landed
   task automatic lines(input logic f, input logic n);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK({fl_n, nl_n}, {f, n})
   endtask
   // Fire one source through the model
   task automatic pulse(input logic [31:0] m);
      fire <= m;
      @(posedge sys_clk);
      fire <= zero;
   endtask
   // Compare each bus answer with the oldest note
   always @(posedge sys_clk) begin
      if ((b_v && b_k) || (r_v && r_k)) begin
         e = note.pop_front();
         `CHK(b_v ? {b_rs, zero} : {r_rs, r_d}, e)
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      // Reset images, write-only read, unmapped places
      bus(1, `VIC_OFF_PENDING, zero, rs_ok);
      bus(1, `VIC_OFF_ENABLE, zero, rs_ok);
      bus(1, `VIC_OFF_CORE_STAT, zero, rs_ok);
      bus(1, `VIC_OFF_DEBUG, zero, rs_ok);
      bus(1, `VIC_OFF_FF_STATE, zero, rs_ok);
      bus(1, `VIC_OFF_STRAY, zero, rs_ok);
      bus(1, `VIC_OFF_ENABLE_CMD, zero, rs_ok);
      bus(1, 12'h118, zero, rs_er);
      bus(0, 12'h13C, 32'h5, rs_er);
      // Stray address returned while nothing is current
      h = $random(seed);
      bus(0, `VIC_OFF_STRAY, h, rs_ok);
      bus(1, `VIC_OFF_STRAY, h, rs_ok);
      bus(1, `VIC_OFF_NORM_VECT, h, rs_ok);
      bus(1, `VIC_OFF_FAST_VECT, h, rs_ok);
      // Random enable and disable sets; zeros leave bits alone
      v = $random(seed);
      en = v;
      bus(0, `VIC_OFF_ENABLE_CMD, v, rs_ok);
      bus(0, `VIC_OFF_ENABLE_CMD, zero, rs_ok);
      v = $random(seed);
      en &= ~v;
      bus(0, `VIC_OFF_DISABLE_CMD, v, rs_ok);
      bus(1, `VIC_OFF_ENABLE, en, rs_ok);
      // Pending from a source edge, set and clear commands
      pulse(32'h0000_0020);
      v = $random(seed);
      pend = v | 32'h0000_0020;
      bus(0, `VIC_OFF_SET_CMD, v, rs_ok);
      bus(1, `VIC_OFF_PENDING, pend, rs_ok);
      v = $random(seed);
      pend &= ~v;
      bus(0, `VIC_OFF_CLEAR_CMD, v, rs_ok);
      bus(1, `VIC_OFF_PENDING, pend, rs_ok);
      bus(1, `VIC_OFF_ENABLE, en, rs_ok);
      bus(0, `VIC_OFF_CLEAR_CMD, 32'hFFFF_FFFF, rs_ok);
      bus(0, `VIC_OFF_DISABLE_CMD, 32'hFFFF_FFFF, rs_ok);
      lines(1'b1, 1'b1);
      // Fast source, general mask and protection bit
      h = $random(seed);
      bus(0, `VIC_OFF_FAST_HANDLER, h, rs_ok);
      bus(0, `VIC_OFF_ENABLE_CMD, 32'h0000_0081, rs_ok);
      bus(0, `VIC_OFF_SET_CMD, 32'h0000_0001, rs_ok);
      lines(1'b0, 1'b1);
      bus(1, `VIC_OFF_CORE_STAT, 32'h1, rs_ok);
      bus(1, `VIC_OFF_FAST_VECT, h, rs_ok);
      bus(0, `VIC_OFF_DEBUG, 32'h2, rs_ok);
      lines(1'b1, 1'b1);
      bus(1, `VIC_OFF_DEBUG, 32'h2, rs_ok);
      bus(0, `VIC_OFF_DEBUG, 32'h1, rs_ok);
      lines(1'b0, 1'b1);
      bus(1, `VIC_OFF_DEBUG, 32'h1, rs_ok);
      bus(0, `VIC_OFF_CLEAR_CMD, 32'h1, rs_ok);
      // Normal source, service and end of service with any value
      h = $random(seed);
      bus(0, `VIC_OFF_NORM_HANDLER, h, rs_ok);
      pulse(32'h0000_0080);
      lines(1'b1, 1'b0);
      bus(1, `VIC_OFF_CORE_STAT, 32'h2, rs_ok);
      bus(1, `VIC_OFF_NORM_VECT, h, rs_ok);
      lines(1'b1, 1'b1);
      `CHK(cur, 5'h07)
      bus(0, `VIC_OFF_EOS_CMD, $random(seed), rs_ok);
      lines(1'b1, 1'b0);
      // Fast forcing on, routing, then random off
      bus(0, `VIC_OFF_FF_ON, 32'hFFFF_FFFF, rs_ok);
      bus(1, `VIC_OFF_FF_STATE, `VIC_FF_WRITABLE, rs_ok);
      lines(1'b0, 1'b1);
      v = $random(seed);
      bus(0, `VIC_OFF_FF_OFF, v, rs_ok);
      bus(1, `VIC_OFF_FF_STATE, `VIC_FF_WRITABLE & ~v, rs_ok);
      final_report();
   end
endmodule
`default_nettype wire
